// ### core/tcr_timer_ctrl.sv
// Timer control register block: general timer with prescaler and
// the paired short/long waveform counters, behind an Avalon-MM slave.
// Assumes inputs synchronous to mclk_i and a single bus master.
//
// Functional notes
// - Mode bit 2 written one reloads general timer
// - Mode bits 1:0 read 11, writes ignored
// - Prescaler: 8-bit register, 6-bit down-counter
// - Prescale bits 7:2 give modulo 1..64
// - Prescale bit1 clock source, bit0 count mode
// - Short 8-bit and long 16-bit counters
// - Control bit 7 selects demodulate or transmit
// - Bits 3:2 pick normal, ping-pong, forced levels
// - Bit 6 routes combined output to pin
// - Bits 5:4 combine outputs AND/OR/NOR/NAND
// - Long load high byte, read/write, reset zero
// - Long load low byte, read/write, reset zero
// - Disabled short output is inverted bit 1
// - Short start loads low or high by level
// - End-of-count stops or reloads per mode
`timescale 1ns/10ps
`default_nettype none
module tcr_timer_ctrl
  import tcr_pkg::*;
#(
  parameter int PRE_W = 6,
  parameter int SHORT_W = 8,
  parameter int LONG_W = 16
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [TCR_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [TCR_DW-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [TCR_DW-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic external_timer_input_pin_i,
  input wire logic current_pin_gpio_i,
  output logic general_timer_out_o,
  output logic short_counter_output_o,
  output logic long_counter_output_o,
  output logic controlled_current_pin_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Bus slave: one wait state, answer on the second edge
  // ---------------------------------------------------------------
  logic ack_q;
  logic req;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic wr_ok;
  logic [7:0] rd_mux;
  logic [TCR_DW-1:0] rdata_q;

  assign req = (avs_read_i || avs_write_i) && !ack_q;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
  assign wr_acc = avs_write_i && ack_q;
  assign rd_acc = avs_read_i && ack_q;
  assign idx = avs_address_i[TCR_AW-1:TCR_IDX_LSB];
  assign wbyte = avs_writedata_i[7:0];
  assign wr_ok = wr_acc && avs_byteenable_i[0];
  assign avs_readdata_o = rdata_q;

  // Ack pulse ends each access
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  tcr_ctrl_t ctrl_q;
  logic [7:0] pre_q;
  logic [3:0] gt_upper_q;
  logic gt_run_q;
  logic [7:0] gt_init_q;
  logic [7:0] sload_lo_q;
  logic [7:0] sload_hi_q;
  logic [7:0] lload_lo_q;
  logic [7:0] lload_hi_q;
  logic [3:0] wave_en_q;
  logic [NUM_EV-1:0] mask_q;
  logic gt_eot;

  // Bus-written byte registers; all read back except gt_init_q
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= tcr_ctrl_t'(RST_BYTE);
      pre_q <= RST_BYTE;
      gt_upper_q <= '0;
      gt_init_q <= RST_BYTE;
      sload_lo_q <= RST_BYTE;
      sload_hi_q <= RST_BYTE;
      lload_lo_q <= RST_BYTE;
      lload_hi_q <= RST_BYTE;
      wave_en_q <= '0;
      mask_q <= '0;
    end else if (wr_ok) begin
      case (idx)
        IDX_CTRL: ctrl_q <= tcr_ctrl_t'(wbyte);
        IDX_GT_PRE: pre_q <= wbyte;
        IDX_GT_MODE: gt_upper_q <= wbyte[7:4];
        IDX_GT_COUNT: gt_init_q <= wbyte;
        IDX_SLOAD_LO: sload_lo_q <= wbyte;
        IDX_SLOAD_HI: sload_hi_q <= wbyte;
        IDX_LLOAD_LO: lload_lo_q <= wbyte;
        IDX_LLOAD_HI: lload_hi_q <= wbyte;
        IDX_WAVE_EN: wave_en_q <= wbyte[3:0];
        IDX_IRQ_MASK: mask_q <= wbyte[NUM_EV-1:0];
        default: ;
      endcase
    end
  end

  // Enable-count bit; single-pass end clears it
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gt_run_q <= 1'b0;
    end else if (wr_ok && idx == IDX_GT_MODE) begin
      gt_run_q <= wbyte[GT_RUN_BIT];
    end else if (gt_eot && !pre_q[PRE_MODE_BIT]) begin
      gt_run_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // General timer and its prescaler
  // ---------------------------------------------------------------
  logic gt_load;
  logic ext_prev_q;
  logic pre_pulse;
  logic pre_tick;
  logic [PRE_W-1:0] pre_cnt;
  logic [7:0] gt_cnt_q;
  logic gt_out_q;

  assign gt_load = wr_ok && idx == IDX_GT_MODE && wbyte[GT_LOAD_BIT];

  // Rising edges of the timer input pin
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= external_timer_input_pin_i;
    end
  end

  // Internal source counts every cycle, external counts pin edges
  assign pre_pulse = pre_q[PRE_SRC_BIT] ? 1'b1 :
                     (external_timer_input_pin_i && !ext_prev_q);

  tcr_prescaler #(
    .W(PRE_W)
  ) u_prescaler (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .restart_i(gt_load),
    .pulse_i(pre_pulse),
    .modulo_i(pre_q[7:8-PRE_W]),
    .tick_o(pre_tick),
    .count_o(pre_cnt)
  );

  assign gt_eot = gt_run_q && pre_tick && gt_cnt_q == GT_LAST;

  // Down-counter with load and end-of-count handling
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gt_cnt_q <= RST_BYTE;
    end else if (gt_load) begin
      gt_cnt_q <= gt_init_q;
    end else if (gt_eot && pre_q[PRE_MODE_BIT]) begin
      gt_cnt_q <= gt_init_q;
    end else if (gt_run_q && pre_tick) begin
      gt_cnt_q <= gt_cnt_q - GT_LAST;
    end
  end

  // Timer output: set by load, toggled at end-of-count
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gt_out_q <= 1'b0;
    end else if (gt_load) begin
      gt_out_q <= 1'b1;
    end else if (gt_eot) begin
      gt_out_q <= !gt_out_q;
    end
  end

  // ---------------------------------------------------------------
  // Short and long waveform counters (transmit mode)
  // ---------------------------------------------------------------
  tcr_sc_state_t sc_state_q;
  logic [SHORT_W-1:0] sc_cnt_q;
  logic sc_out_q;
  logic sc_en_prev_q;
  logic sc_start;
  logic sc_end;
  logic [LONG_W-1:0] lc_cnt_q;
  logic lc_out_q;
  logic lc_run_q;
  logic lc_en_prev_q;
  logic lc_start;
  logic lc_end;
  logic pp_long_q;
  logic pingpong;
  logic transmit;
  logic lc_out_eff;

  assign transmit = !ctrl_q.demod;
  assign pingpong = ctrl_q.submode == SUB_PINGPONG;
  assign sc_start = wave_en_q[WE_SHORT_EN] && !sc_en_prev_q;
  assign lc_start = wave_en_q[WE_LONG_EN] && !lc_en_prev_q;
  assign sc_end = transmit && sc_state_q == SC_RUN && sc_cnt_q == '0
                  && !(pingpong && pp_long_q);
  assign lc_end = transmit && lc_run_q && lc_cnt_q == '0
                  && (!pingpong || pp_long_q);

  // Enable edge history
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sc_en_prev_q <= 1'b0;
      lc_en_prev_q <= 1'b0;
    end else begin
      sc_en_prev_q <= wave_en_q[WE_SHORT_EN];
      lc_en_prev_q <= wave_en_q[WE_LONG_EN];
    end
  end

  // Short counter sequencing, count and output
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sc_state_q <= SC_IDLE;
      sc_cnt_q <= '0;
      sc_out_q <= 1'b1;
    end else if (!wave_en_q[WE_SHORT_EN]) begin
      sc_state_q <= SC_IDLE;
      sc_out_q <= !ctrl_q.init_short;
    end else if (sc_start) begin
      sc_state_q <= SC_RUN;
      sc_out_q <= ctrl_q.init_short;
      sc_cnt_q <= ctrl_q.init_short ? sload_hi_q : sload_lo_q;
    end else if (lc_end && pingpong && sc_state_q == SC_STOP) begin
      sc_state_q <= SC_RUN;
      sc_cnt_q <= sc_out_q ? sload_hi_q : sload_lo_q;
    end else begin
      case (sc_state_q)
        SC_RUN: begin
          if (sc_end) begin
            sc_out_q <= !sc_out_q;
            sc_cnt_q <= sc_out_q ? sload_lo_q : sload_hi_q;
            if (pingpong || !wave_en_q[WE_SHORT_MOD]) begin
              sc_state_q <= SC_STOP;
            end
          end else if (transmit && !(pingpong && pp_long_q)) begin
            sc_cnt_q <= sc_cnt_q - SHORT_W'(1);
          end
        end
        SC_IDLE: sc_state_q <= SC_IDLE;
        SC_STOP: sc_state_q <= SC_STOP;
        default: sc_state_q <= SC_IDLE;
      endcase
    end
  end

  // Ping-pong turn: long runs after short ends, short after long
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pp_long_q <= 1'b0;
    end else if (!pingpong) begin
      pp_long_q <= 1'b0;
    end else if (sc_end) begin
      pp_long_q <= 1'b1;
    end else if (lc_end) begin
      pp_long_q <= 1'b0;
    end
  end

  // Long counter count, run flag and output
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lc_cnt_q <= '0;
      lc_run_q <= 1'b0;
      lc_out_q <= 1'b0;
    end else if (!wave_en_q[WE_LONG_EN]) begin
      lc_run_q <= 1'b0;
      lc_out_q <= ctrl_q.init_long;
    end else if (lc_start) begin
      lc_run_q <= 1'b1;
      lc_out_q <= ctrl_q.init_long;
      lc_cnt_q <= {lload_hi_q, lload_lo_q};
    end else if (lc_end) begin
      lc_out_q <= !lc_out_q;
      lc_cnt_q <= {lload_hi_q, lload_lo_q};
      lc_run_q <= pingpong || wave_en_q[WE_LONG_MOD];
    end else if (transmit && lc_run_q && (!pingpong || pp_long_q)) begin
      lc_cnt_q <= lc_cnt_q - LONG_W'(1);
    end
  end

  // Forced submodes override the long counter output
  always_comb begin
    case (ctrl_q.submode)
      SUB_FORCE0: lc_out_eff = 1'b0;
      SUB_FORCE1: lc_out_eff = 1'b1;
      default: lc_out_eff = lc_out_q;
    endcase
  end

  // ---------------------------------------------------------------
  // Output combination and pin routing
  // ---------------------------------------------------------------
  logic combined;

  always_comb begin
    case (ctrl_q.combine)
      LOG_AND: combined = sc_out_q & lc_out_eff;
      LOG_OR: combined = sc_out_q | lc_out_eff;
      LOG_NOR: combined = !(sc_out_q | lc_out_eff);
      LOG_NAND: combined = !(sc_out_q & lc_out_eff);
      default: combined = 1'b0;
    endcase
  end

  assign controlled_current_pin_o = ctrl_q.route_sel ? combined : current_pin_gpio_i;
  assign general_timer_out_o = gt_out_q;
  assign short_counter_output_o = sc_out_q;
  assign long_counter_output_o = lc_out_eff;

  // ---------------------------------------------------------------
  // Interrupts: sticky status, cleared by reading, set wins
  // ---------------------------------------------------------------
  logic [NUM_EV-1:0] stat_q;
  logic [NUM_EV-1:0] events;
  logic stat_rd;

  assign events = {lc_end, sc_end, gt_eot};
  assign stat_rd = rd_acc && idx == IDX_IRQ_STAT;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_rd ? '0 : stat_q) | events;
    end
  end

  assign irq_o = |(stat_q & mask_q);

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    case (idx)
      IDX_CTRL: rd_mux = ctrl_q;
      IDX_GT_PRE: rd_mux = pre_q;
      IDX_GT_MODE: rd_mux = {gt_upper_q, gt_run_q, 1'b0, GT_RSVD_VAL};
      IDX_GT_COUNT: rd_mux = gt_cnt_q;
      IDX_SLOAD_LO: rd_mux = sload_lo_q;
      IDX_SLOAD_HI: rd_mux = sload_hi_q;
      IDX_LLOAD_LO: rd_mux = lload_lo_q;
      IDX_LLOAD_HI: rd_mux = lload_hi_q;
      IDX_WAVE_EN: rd_mux = {4'h0, wave_en_q};
      IDX_IRQ_STAT: rd_mux = {5'h00, stat_q};
      IDX_IRQ_MASK: rd_mux = {5'h00, mask_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // Captured in the wait cycle, stands through the answer edge
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= '0;
    end else if (req && avs_read_i) begin
      rdata_q <= {24'h000000, rd_mux};
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_mode_load;
    gt_load;
  endsequence

  sequence s_gt_end;
    gt_eot;
  endsequence

  timer_load_a: assert property (s_mode_load |=> gt_cnt_q == $past(gt_init_q))
    else $error("general timer not loaded");
  mode_rsvd_a: assert property (rd_acc && idx == IDX_GT_MODE |-> rdata_q[1:0] == 2'h3)
    else $error("reserved mode bits not 11");
  presc_range_a: assert property (pre_tick |=> pre_cnt == $past(pre_q[7:2]) - 6'h01)
    else $error("prescaler reload wrong");
  single_stop_a: assert property (s_gt_end ##0 !pre_q[0] && !wr_ok |=> !gt_run_q)
    else $error("single pass did not stop");
  modn_reload_a: assert property (s_gt_end ##0 pre_q[0] && !gt_load |=> gt_cnt_q == $past(gt_init_q))
    else $error("modulo reload missing");
  short_idle_a: assert property (!wave_en_q[0] |=> sc_out_q == !$past(ctrl_q.init_short))
    else $error("idle short output wrong");
  short_start_a: assert property (sc_start |=> sc_out_q == $past(ctrl_q.init_short)
      && sc_cnt_q == ($past(ctrl_q.init_short) ? $past(sload_hi_q) : $past(sload_lo_q)))
    else $error("short start wrong");
  long_force_a: assert property (ctrl_q.submode[1] |-> long_counter_output_o == ctrl_q.submode[0])
    else $error("forced long level wrong");
  pin_route_a: assert property (!ctrl_q.route_sel |-> controlled_current_pin_o == current_pin_gpio_i)
    else $error("pin not plain io");
  nand_comb_a: assert property (ctrl_q.route_sel && ctrl_q.combine == 2'h3
      |-> controlled_current_pin_o == !(sc_out_q && lc_out_eff))
    else $error("nand combine wrong");
  read_wait_a: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read answer not after one wait");

endmodule
`default_nettype wire

// ### inc/tcr_pkg.sv
// Shared constants and types of the timer control register block.
// Assumes a 32-bit Avalon-MM slave port with byte addressing.
package tcr_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int TCR_AW = 10;
  localparam int TCR_DW = 32;
  localparam int TCR_IDX_LSB = 2;

  // ---------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_WAVE_EN = 8'h00;
  localparam logic [7:0] IDX_CTRL = 8'h01;
  localparam logic [7:0] IDX_SLOAD_LO = 8'h02;
  localparam logic [7:0] IDX_SLOAD_HI = 8'h03;
  localparam logic [7:0] IDX_LLOAD_LO = 8'h06;
  localparam logic [7:0] IDX_LLOAD_HI = 8'h07;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h08;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h09;
  localparam logic [7:0] IDX_GT_MODE = 8'hF1;
  localparam logic [7:0] IDX_GT_COUNT = 8'hF2;
  localparam logic [7:0] IDX_GT_PRE = 8'hF3;

  // ---------------------------------------------------------------
  // Field positions and fixed values
  // ---------------------------------------------------------------
  localparam int GT_LOAD_BIT = 2;
  localparam int GT_RUN_BIT = 3;
  localparam logic [1:0] GT_RSVD_VAL = 2'h3;
  localparam int PRE_SRC_BIT = 1;
  localparam int PRE_MODE_BIT = 0;
  localparam int WE_SHORT_EN = 0;
  localparam int WE_LONG_EN = 1;
  localparam int WE_SHORT_MOD = 2;
  localparam int WE_LONG_MOD = 3;
  localparam logic [7:0] GT_LAST = 8'h01;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Interrupt event bits
  localparam int EV_GT = 0;
  localparam int EV_SHORT = 1;
  localparam int EV_LONG = 2;
  localparam int NUM_EV = 3;

  // Transmit submodes and output combinations
  localparam logic [1:0] SUB_NORMAL = 2'h0;
  localparam logic [1:0] SUB_PINGPONG = 2'h1;
  localparam logic [1:0] SUB_FORCE0 = 2'h2;
  localparam logic [1:0] SUB_FORCE1 = 2'h3;
  localparam logic [1:0] LOG_AND = 2'h0;
  localparam logic [1:0] LOG_OR = 2'h1;
  localparam logic [1:0] LOG_NOR = 2'h2;
  localparam logic [1:0] LOG_NAND = 2'h3;

  // Common waveform-timer control layout, bit 7 down to bit 0
  typedef struct packed {
    logic demod;
    logic route_sel;
    logic [1:0] combine;
    logic [1:0] submode;
    logic init_short;
    logic init_long;
  } tcr_ctrl_t;

  // Short counter sequencing
  typedef enum logic [1:0] {SC_IDLE, SC_RUN, SC_STOP} tcr_sc_state_t;

endpackage

// ### core/tcr_prescaler.sv
// Divide-by-n prescaler feeding the general timer.
// Assumes count pulses synchronous to mclk_i, one cycle each.
`timescale 1ns/10ps
`default_nettype none
module tcr_prescaler #(
  parameter int W = 6
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic restart_i,
  input wire logic pulse_i,
  input wire logic [W-1:0] modulo_i,
  output logic tick_o,
  output logic [W-1:0] count_o
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] reload;

  // Field value n divides by n, zero divides by two to the W
  assign reload = modulo_i - W'(1);

  // ---------------------------------------------------------------
  // Down-counter
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
    end else if (restart_i) begin
      cnt_q <= reload;
    end else if (pulse_i) begin
      cnt_q <= (cnt_q == '0) ? reload : cnt_q - W'(1);
    end
  end

  assign tick_o = pulse_i && (cnt_q == '0) && !restart_i;
  assign count_o = cnt_q;

endmodule
`default_nettype wire

// ### tb/tcr_pins_model.sv
// Model of the pins around the timer block: timer input and I/O level.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/10ps
`default_nettype none
module tcr_pins_model (
  input wire logic mclk_i,
  output logic ext_pin_o,
  output logic gpio_o
);
  // Both pins idle low
  initial begin
    ext_pin_o = 1'b0;
    gpio_o = 1'b0;
  end
  // Rising edges on the timer input, spaced well apart
  task pulse(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      ext_pin_o <= 1'b1;
      repeat (3) @(posedge mclk_i);
      ext_pin_o <= 1'b0;
      repeat (3) @(posedge mclk_i);
    end
  endtask
  // Ordinary I/O level for the current pin
  task set_gpio(input logic v);
    @(posedge mclk_i);
    gpio_o <= v;
  endtask
endmodule
`default_nettype wire

// ### tb/tb_tcr_timer_ctrl.sv
// Self-checking bench of the timer control register block.
// Assumes one clock domain and a bus answer within the timeout.
`timescale 1ns/10ps
`default_nettype none
module tb_tcr_timer_ctrl;
  import tcr_pkg::*;
  logic mclk_i;
  logic reset_n_i;
  logic [TCR_AW-1:0] addr;
  logic rd_s;
  logic wr_s;
  logic [TCR_DW-1:0] wdata;
  logic [3:0] be;
  logic [TCR_DW-1:0] rdata;
  logic waitreq;
  logic ext_pin;
  logic gpio;
  logic gt_out;
  logic short_out;
  logic long_out;
  logic pin_out;
  logic irq;
  int errors;
  int checked;

  tcr_timer_ctrl dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .avs_address_i(addr),
    .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .external_timer_input_pin_i(ext_pin), .current_pin_gpio_i(gpio),
    .general_timer_out_o(gt_out), .short_counter_output_o(short_out),
    .long_counter_output_o(long_out), .controlled_current_pin_o(pin_out), .irq_o(irq));
  tcr_pins_model pins_u (.mclk_i(mclk_i), .ext_pin_o(ext_pin), .gpio_o(gpio));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task stop_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low
  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] en,
           output logic [7:0] q);
    int n;
    @(posedge mclk_i);
    addr <= {idx, 2'h0};
    rd_s <= !w;
    wr_s <= w;
    wdata <= {24'h0, d};
    be <= en;
    n = 0;
    // Request stands until the edge at which waitrequest is seen low
    do begin
      @(posedge mclk_i);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    q = rdata[7:0];
    rd_s <= 1'b0;
    wr_s <= 1'b0;
    if (waitreq !== 1'b0) begin
      errors++;
      $display("BAD %0t bus hang", $time);
      stop_test();
    end
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, 4'hF, q);
  endtask
  task rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, 4'hF, q);
    chk(q, exp);
  endtask
  task cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset;
    logic [7:0] q;
    rd(IDX_CTRL, 8'h00);
    rd(IDX_LLOAD_LO, 8'h00);
    rd(IDX_LLOAD_HI, 8'h00);
    rd(IDX_GT_PRE, 8'h00);
    rd(IDX_GT_MODE, 8'h03);
    cyc(1);
    chk({7'h0, short_out}, 8'h01);
    chk({7'h0, long_out}, 8'h00);
    chk({7'h0, pin_out}, {7'h0, gpio});
    wr(IDX_LLOAD_LO, 8'hA5);
    wr(IDX_LLOAD_HI, 8'h5A);
    bus(1'b1, IDX_LLOAD_LO, 8'h00, 4'hE, q);
    rd(IDX_LLOAD_LO, 8'hA5);
    rd(IDX_LLOAD_HI, 8'h5A);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    wr(IDX_GT_PRE, 8'hFD);
    rd(IDX_GT_PRE, 8'hFD);
    wr(IDX_GT_MODE, 8'hF0);
    rd(IDX_GT_MODE, 8'hF3);
    wr(IDX_GT_MODE, 8'h04);
    rd(IDX_GT_MODE, 8'h03);
  endtask
  // General timer single pass, interrupt, then modulo-n
  task t_general;
    int tog;
    logic last;
    wr(IDX_IRQ_MASK, 8'h01);
    rd(IDX_IRQ_STAT, 8'h00);
    wr(IDX_GT_COUNT, 8'h10);
    wr(IDX_GT_PRE, 8'h06);
    wr(IDX_GT_MODE, 8'h0C);
    cyc(2);
    chk({7'h0, gt_out}, 8'h01);
    cyc(40);
    chk({7'h0, gt_out}, 8'h00);
    chk({7'h0, irq}, 8'h01);
    wr(IDX_IRQ_MASK, 8'h00);
    cyc(1);
    chk({7'h0, irq}, 8'h00);
    rd(IDX_GT_MODE, 8'h03);
    rd(IDX_IRQ_STAT, 8'h01);
    rd(IDX_IRQ_STAT, 8'h00);
    wr(IDX_GT_PRE, 8'h07);
    wr(IDX_GT_MODE, 8'h0C);
    tog = 0;
    last = gt_out;
    repeat (100) begin
      cyc(1);
      if (gt_out !== last) tog++;
      last = gt_out;
    end
    chk({7'h0, tog >= 4}, 8'h01);
    wr(IDX_GT_MODE, 8'h00);
    wr(IDX_GT_COUNT, 8'h02);
    wr(IDX_GT_PRE, 8'h12);
    wr(IDX_GT_MODE, 8'h0C);
    cyc(5);
    chk({7'h0, gt_out}, 8'h01);
    cyc(10);
    chk({7'h0, gt_out}, 8'h00);
    wr(IDX_GT_PRE, 8'h04);
    wr(IDX_GT_MODE, 8'h0C);
    cyc(20);
    chk({7'h0, gt_out}, 8'h01);
    pins_u.pulse(3);
    cyc(4);
    chk({7'h0, gt_out}, 8'h00);
    rd(IDX_IRQ_STAT, 8'h01);
  endtask
  // Forced long levels through every combination code and the pin route
  task t_combine;
    tcr_ctrl_t c;
    logic e;
    for (int k = 0; k < 8; k++) begin
      c = '0;
      c.route_sel = 1'b1;
      c.combine = k[2:1];
      c.submode = k[0] ? SUB_FORCE1 : SUB_FORCE0;
      wr(IDX_CTRL, c);
      cyc(1);
      case (c.combine)
        LOG_AND: e = k[0];
        LOG_OR: e = 1'b1;
        LOG_NOR: e = 1'b0;
        default: e = !k[0];
      endcase
      chk({7'h0, long_out}, {7'h0, k[0]});
      chk({7'h0, pin_out}, {7'h0, e});
    end
    wr(IDX_CTRL, 8'h00);
    for (int v = 0; v < 2; v++) begin
      pins_u.set_gpio(v[0]);
      cyc(2);
      chk({7'h0, pin_out}, {7'h0, v[0]});
    end
  endtask
  // Short counter start level and choice of load register
  task t_short;
    wr(IDX_SLOAD_LO, 8'h03);
    wr(IDX_SLOAD_HI, 8'hFF);
    for (int v = 0; v < 2; v++) begin
      wr(IDX_CTRL, {6'h0, v[0], 1'b0});
      cyc(2);
      chk({7'h0, short_out}, {7'h0, !v[0]});
      wr(IDX_WAVE_EN, 8'h01);
      cyc(2);
      chk({7'h0, short_out}, {7'h0, v[0]});
      cyc(10);
      chk({7'h0, short_out}, 8'h01);
      wr(IDX_WAVE_EN, 8'h00);
    end
    wr(IDX_CTRL, 8'h00);
  endtask
  // Long counter start level, paired 16-bit load, single pass, demodulation freeze
  task t_long;
    rd(IDX_IRQ_STAT, 8'h02);
    wr(IDX_LLOAD_LO, 8'h02);
    wr(IDX_LLOAD_HI, 8'h01);
    wr(IDX_CTRL, 8'h01);
    cyc(2);
    chk({7'h0, long_out}, 8'h01);
    wr(IDX_WAVE_EN, 8'h02);
    cyc(259);
    chk({7'h0, long_out}, 8'h01);
    cyc(3);
    chk({7'h0, long_out}, 8'h00);
    rd(IDX_IRQ_STAT, 8'h04);
    wr(IDX_WAVE_EN, 8'h00);
    wr(IDX_CTRL, 8'h81);
    wr(IDX_WAVE_EN, 8'h02);
    cyc(300);
    chk({7'h0, long_out}, 8'h01);
    rd(IDX_IRQ_STAT, 8'h00);
    wr(IDX_WAVE_EN, 8'h00);
    wr(IDX_CTRL, 8'h00);
  endtask

  // ------------------------------------------------------------
  // Clock, reset and main sequence
  // ------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = !mclk_i;
  end
  initial begin
    errors = 0;
    checked = 0;
    reset_n_i = 1'b0;
    addr = '0;
    rd_s = 1'b0;
    wr_s = 1'b0;
    wdata = '0;
    be = 4'hF;
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_general();
    t_combine();
    t_short();
    t_long();
    stop_test();
  end
endmodule
`default_nettype wire
